/* File: issw_mode_switch.sv */
`timescale 1ns/1ps
`include "issw_consts.svh"
// Operation
// - select bit: 1 legacy, 0 native
// - jump-to-native switches to native target
// - branch-to-legacy switches to legacy target
// - return restores interrupted context's set
// - interruptions always switch to native
// - native mode disables segmentation
// - native mode: 64-bit addresses, translation on
// - legacy: narrow ops, native registers hidden
// - legacy: segment checks, low 4G region 0
// - legacy: fetches and data little-endian
// - legacy: superseded resource access intercepted
// - disable bit faults jump and branch
// - return and interruption ignore disable bit
// - absolute jump: displacement plus base, zero upper
// - register jump: operand plus base, zero upper
// - jump targets 16-byte aligned, below 4G
// - pending numeric exception nullifies jump, faults
// - transitions keep privilege level
// - branch pointer from register, legacy rebased
// - bad legacy target gives protection fault
// - legacy registers map onto native 8..31
module issw_mode_switch (
  input wire logic clock,
  input wire logic rst_n,
  input wire issw_pkg::issw_op_t op,            // Transition request, one cycle
  input wire logic [31:0] operand,              // Displacement/register/branch
  input wire logic operand_16,                  // Operand is 16-bit wide
  input wire logic interrupt_req,               // Interruption pulse
  input wire logic ret_to_legacy,               // Saved select bit for return
  input wire logic [63:0] ret_pointer,          // Saved resume pointer
  input wire logic transition_disable_bit,      // Disable bit from status
  input wire logic fp_pending,                  // Legacy numeric exc pending
  input wire logic [31:0] code_segment_base,    // Code segment base
  input wire logic [31:0] code_segment_limit,   // Code segment limit
  input wire logic cs_priv_bad,                 // Code segment privilege bad
  input wire issw_pkg::issw_lmode_t lmode_setup, // Legacy sub-mode set up
  input wire logic [63:0] int_vector,           // Interruption handler ptr
  input wire logic [1:0] cpl_in,                // Current privilege level
  input wire logic [63:0] va_in,                // Computed address
  input wire logic [31:0] seg_base,             // Data segment base
  input wire logic sys_access,                  // Superseded resource access
  input wire logic [4:0] reg_idx,               // Register being referenced
  input wire logic reg_is_native_only,          // Branch/pred/app/ctl reg
  output logic instruction_set_select_bit,      // Current set
  output issw_pkg::issw_lmode_t lmode,          // Legacy sub-mode
  output logic [63:0] native_instruction_pointer, // Committed pointer
  output logic [31:0] legacy_instruction_pointer, // Legacy pointer
  output logic redirect,                        // Pointer committed pulse
  output logic [2:0] fault_code,                // Fault kind, registered
  output logic fault_valid,                     // Fault pulse
  output logic [1:0] cpl_out,                   // Privilege after transition
  output logic [63:0] va_out,                   // Address to translation
  output logic xlate_en,                        // Translation enable
  output logic seg_check_en,                    // Segment checks enable
  output logic force_le,                        // Force little-endian
  output logic narrow_ops,                      // 16/32-bit operation limit
  output logic reg_hidden,                      // Register not visible
  output logic reg_mapped                       // Register holds legacy state
);
  import issw_pkg::*;

  // All state of the block
  typedef struct packed {
    issw_state_t st;
    logic sel;
    issw_lmode_t lm;
    logic [63:0] ip;
    logic [31:0] lip;
    logic redir;
    logic [2:0] flt;
    logic fv;
    logic [1:0] cpl;
    logic [63:0] va;
  } issw_regs_t;

  issw_regs_t q_r;   // Registered state
  issw_regs_t q_nxt; // Next state
  issw_tgt_if tgt(); // Target calculator link
  logic [31:0] op_ext; // Operand sized by width
  logic jump_op;       // Jump to native requested
  logic br_op;         // Branch to legacy requested

  // Mask jump operand (displacement or register) to 16 bits when narrow
  function automatic logic [31:0] issw_size(input logic [31:0] v,
                                            input logic n16);
    issw_size = n16 ? {16'h0000, v[15:0]} : v;
  endfunction : issw_size

  // True for registers carrying legacy state
  function automatic logic issw_in_map(input logic [4:0] i);
    issw_in_map = (i >= `ISSW_MAP_LO) && (i <= `ISSW_MAP_HI);
  endfunction : issw_in_map

  assign op_ext = issw_size(operand, operand_16);
  assign jump_op = (op == ISSW_OP_JMP_ABS) || (op == ISSW_OP_JMP_REG);
  assign br_op = (op == ISSW_OP_BR_LEGACY);

  // Feed the target calculator
  always_comb begin
    unique case (op)
      ISSW_OP_BR_LEGACY: tgt.kind = 2'h2;
      ISSW_OP_JMP_REG: tgt.kind = 2'h1;
      default: tgt.kind = 2'h0;
    endcase
    // Branch source keeps all 32 bits, only jumps honour the 16-bit width
    tgt.operand = br_op ? operand : op_ext;
    tgt.cs_base = code_segment_base;
    tgt.cs_limit = code_segment_limit;
  end

  // Target calculator
  issw_target_calc u_calc (
    .t(tgt.calc)
  );

  // Next-state logic
  always_comb begin
    q_nxt = q_r;
    q_nxt.redir = 1'b0;
    q_nxt.fv = 1'b0;
    q_nxt.flt = `ISSW_FLT_NONE;
    q_nxt.st = ISSW_ST_IDLE;
    q_nxt.cpl = cpl_in;
    // Address path per mode
    if (q_r.sel == `ISSW_SEL_NATIVE) begin
      q_nxt.va = va_in;
    end else begin
      q_nxt.va = {32'h0000_0000,
                  va_in[`ISSW_LEGACY_ABITS-1:0] + seg_base};
    end
    if (interrupt_req) begin
      // Interruption wins, ignores disable bit
      q_nxt.sel = `ISSW_SEL_NATIVE;
      q_nxt.ip = int_vector;
      q_nxt.redir = 1'b1;
      q_nxt.st = ISSW_ST_COMMIT;
    end else if (op == ISSW_OP_RETURN) begin
      // Return restores saved set, ignores disable bit
      q_nxt.sel = ret_to_legacy;
      q_nxt.ip = ret_pointer;
      q_nxt.lip = ret_pointer[31:0];
      if (ret_to_legacy) begin
        q_nxt.lm = lmode_setup;
      end
      q_nxt.redir = 1'b1;
      q_nxt.st = ISSW_ST_COMMIT;
    end else if ((jump_op && q_r.sel == `ISSW_SEL_LEGACY) ||
                 (br_op && q_r.sel == `ISSW_SEL_NATIVE)) begin
      if (transition_disable_bit) begin
        // Disabled transition faults, no switch
        q_nxt.flt = `ISSW_FLT_DISABLED;
        q_nxt.fv = 1'b1;
        q_nxt.st = ISSW_ST_FAULT;
      end else if (jump_op && fp_pending) begin
        // Nullified jump
        q_nxt.flt = `ISSW_FLT_FP;
        q_nxt.fv = 1'b1;
        q_nxt.st = ISSW_ST_FAULT;
      end else if (jump_op) begin
        // Commit native target with select bit
        q_nxt.sel = `ISSW_SEL_NATIVE;
        q_nxt.ip = tgt.ip;
        q_nxt.redir = 1'b1;
        q_nxt.st = ISSW_ST_COMMIT;
      end else begin
        // Commit legacy target with select bit
        q_nxt.sel = `ISSW_SEL_LEGACY;
        q_nxt.lm = lmode_setup;
        q_nxt.ip = tgt.ip;
        q_nxt.lip = tgt.lip;
        q_nxt.redir = 1'b1;
        q_nxt.st = ISSW_ST_COMMIT;
        if (tgt.limit_bad || cs_priv_bad) begin
          // Fault reported on the target instruction
          q_nxt.flt = `ISSW_FLT_GP;
          q_nxt.fv = 1'b1;
        end
      end
    end else if (q_r.sel == `ISSW_SEL_LEGACY && sys_access) begin
      // Superseded resource touched in legacy mode
      q_nxt.flt = `ISSW_FLT_INTERCEPT;
      q_nxt.fv = 1'b1;
      q_nxt.st = ISSW_ST_FAULT;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q_r <= '0;
      q_r.sel <= `ISSW_RST_SEL;
      q_r.st <= ISSW_ST_IDLE;
      q_r.lm <= ISSW_LM_REAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs
  assign instruction_set_select_bit = q_r.sel;
  assign lmode = q_r.lm;
  assign native_instruction_pointer = q_r.ip;
  assign legacy_instruction_pointer = q_r.lip;
  assign redirect = q_r.redir;
  assign fault_code = q_r.flt;
  assign fault_valid = q_r.fv;
  assign cpl_out = q_r.cpl;
  assign va_out = q_r.va;
  assign xlate_en = 1'b1;
  assign seg_check_en = q_r.sel;
  assign force_le = q_r.sel;
  assign narrow_ops = q_r.sel;
  assign reg_hidden = q_r.sel & (reg_is_native_only |
                      ~issw_in_map(reg_idx));
  assign reg_mapped = issw_in_map(reg_idx);
endmodule : issw_mode_switch

/* File: issw_consts.svh */
`ifndef ISSW_CONSTS_SVH
`define ISSW_CONSTS_SVH
// Select bit encodings
`define ISSW_SEL_LEGACY 1'b1
`define ISSW_SEL_NATIVE 1'b0
// Reset values
`define ISSW_RST_SEL 1'b0
// Native target alignment, low bits cleared
`define ISSW_ALIGN_BITS 4
// Legacy addressing confined to this many address bits
`define ISSW_LEGACY_ABITS 32
// Register map ranges for legacy state
`define ISSW_MAP_LO 5'h08
`define ISSW_MAP_HI 5'h1F
// Fault codes
`define ISSW_FLT_NONE 3'h0
`define ISSW_FLT_DISABLED 3'h1
`define ISSW_FLT_FP 3'h2
`define ISSW_FLT_GP 3'h3
`define ISSW_FLT_INTERCEPT 3'h4
`endif

/* File: issw_pkg.sv */
package issw_pkg;
  // Transition request kinds
  typedef enum logic [2:0] {
    ISSW_OP_NONE = 3'h0,
    ISSW_OP_JMP_ABS = 3'h1,
    ISSW_OP_JMP_REG = 3'h2,
    ISSW_OP_BR_LEGACY = 3'h3,
    ISSW_OP_RETURN = 3'h4
  } issw_op_t;
  // Controller states, Gray along idle-commit-idle
  typedef enum logic [1:0] {
    ISSW_ST_IDLE = 2'b00,
    ISSW_ST_COMMIT = 2'b01,
    ISSW_ST_FAULT = 2'b11
  } issw_state_t;
  // Legacy operating sub-mode
  typedef enum logic [1:0] {
    ISSW_LM_REAL = 2'h0,
    ISSW_LM_V86 = 2'h1,
    ISSW_LM_PROT = 2'h2
  } issw_lmode_t;
endpackage : issw_pkg

/* File: issw_tgt_if.sv */
`timescale 1ns/1ps
// Target computation request and result between main block and calculator
interface issw_tgt_if;
  logic [1:0] kind;      // 0 jump abs, 1 jump reg, 2 branch legacy
  logic [31:0] operand;  // Displacement, register or branch reg low half
  logic [31:0] cs_base;  // Code segment base
  logic [31:0] cs_limit; // Code segment limit
  logic [63:0] ip;       // Native pointer result
  logic [31:0] lip;      // Legacy pointer result
  logic limit_bad;       // Legacy target beyond limit
  modport calc (input kind, operand, cs_base, cs_limit,
                output ip, lip, limit_bad);
  modport user (output kind, operand, cs_base, cs_limit,
                input ip, lip, limit_bad);
endinterface : issw_tgt_if

/* File: issw_target_calc.sv */
`timescale 1ns/1ps
`include "issw_consts.svh"
// Combinational target pointer arithmetic
module issw_target_calc (
  issw_tgt_if.calc t
);
  logic [31:0] sum;  // Operand plus code segment base
  logic [31:0] diff; // Branch target minus code segment base
  // Target arithmetic
  always_comb begin
    sum = t.operand + t.cs_base;
    diff = t.operand - t.cs_base;
    if (t.kind == 2'h2) begin
      // Branch to legacy: upper half zero, legacy pointer rebased
      t.ip = {32'h0000_0000, t.operand};
      t.lip = diff;
      t.limit_bad = (diff > t.cs_limit);
    end else begin
      // Jump to native: aligned, upper half zero
      t.ip = {32'h0000_0000, sum[31:`ISSW_ALIGN_BITS],
              {`ISSW_ALIGN_BITS{1'b0}}};
      t.lip = 32'h0000_0000;
      t.limit_bad = 1'b0;
    end
  end
endmodule : issw_target_calc

/* File: issw_properties.sv */
`timescale 1ns/1ps
// Port-level checks of the mode switch
module issw_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire issw_pkg::issw_op_t op,
  input wire logic [31:0] operand,
  input wire logic interrupt_req,
  input wire logic ret_to_legacy,
  input wire logic transition_disable_bit,
  input wire logic fp_pending,
  input wire logic [31:0] code_segment_base,
  input wire logic [1:0] cpl_in,
  input wire logic [63:0] va_in,
  input wire logic [31:0] seg_base,
  input wire logic sys_access,
  input wire logic instruction_set_select_bit,
  input wire logic [63:0] native_instruction_pointer,
  input wire logic [31:0] legacy_instruction_pointer,
  input wire logic redirect,
  input wire logic [2:0] fault_code,
  input wire logic fault_valid,
  input wire logic [1:0] cpl_out,
  input wire logic [63:0] va_out,
  input wire logic xlate_en,
  input wire logic seg_check_en,
  input wire logic force_le,
  input wire logic cs_priv_bad,
  input wire issw_pkg::issw_lmode_t lmode_setup,
  input wire logic [4:0] reg_idx,
  input wire logic reg_is_native_only,
  input wire issw_pkg::issw_lmode_t lmode,
  input wire logic narrow_ops,
  input wire logic reg_hidden,
  input wire logic reg_mapped
);
  import issw_pkg::*;
  wire sel = instruction_set_select_bit; // Current set
  wire [63:0] ip = native_instruction_pointer; // Committed pointer
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Jump request taken in legacy
  sequence s_jmp;
    (op == ISSW_OP_JMP_ABS || op == ISSW_OP_JMP_REG) && sel && !interrupt_req;
  endsequence
  // Branch request taken in native
  sequence s_br;
    op == ISSW_OP_BR_LEGACY && !sel && !interrupt_req;
  endsequence
  a_disable_fault: assert property (
    s_jmp ##0 transition_disable_bit |=> fault_valid && fault_code == 3'h1
    && sel && !redirect) else $error("disabled jump not faulted");
  a_fp_fault: assert property (
    s_jmp ##0 !transition_disable_bit && fp_pending |=> fault_valid
    && fault_code == 3'h2 && sel && !redirect) else $error("fp jump ran");
  a_jump_target: assert property (
    s_jmp ##0 !transition_disable_bit && !fp_pending |=> redirect && !sel
    && ip[63:32] == 32'h0 && ip[3:0] == 4'h0) else $error("bad jump");
  a_branch_legacy: assert property (
    s_br ##0 !transition_disable_bit |=> redirect && sel
    && ip == {32'h0, $past(operand)} && legacy_instruction_pointer ==
    $past(operand) - $past(code_segment_base)) else $error("bad branch");
  a_int_native: assert property (
    interrupt_req |=> redirect && !sel) else $error("interrupt kept set");
  a_ret_restore: assert property (
    op == ISSW_OP_RETURN && !interrupt_req |=> redirect
    && sel == $past(ret_to_legacy)) else $error("return lost set");
  a_intercept: assert property (
    sys_access && sel && op == ISSW_OP_NONE && !interrupt_req |=>
    fault_valid && fault_code == 3'h4) else $error("no intercept");
  a_cpl_kept: assert property (
    $past(rst_n) |-> cpl_out == $past(cpl_in)) else $error("cpl moved");
  a_mode_views: assert property (
    seg_check_en == sel && force_le == sel && xlate_en)
    else $error("mode views wrong");
  a_flat_native: assert property (
    $past(rst_n) && !$past(sel) |-> va_out == $past(va_in))
    else $error("native address altered");
  a_legacy_addr: assert property (
    $past(rst_n) && $past(sel) |-> va_out == {32'h0,
    $past(va_in[31:0]) + $past(seg_base)}) else $error("legacy address");
  a_gp_fault: assert property (
    s_br ##0 !transition_disable_bit && cs_priv_bad |=> redirect && sel
    && fault_valid && fault_code == 3'h3) else $error("no protection fault");
  a_lmode_set: assert property (
    s_br ##0 !transition_disable_bit |=> lmode == $past(lmode_setup))
    else $error("legacy sub-mode not entered");
  a_narrow_legacy: assert property (
    narrow_ops == sel) else $error("operation width wrong");
  a_reg_visible: assert property (
    reg_hidden == (sel && (reg_is_native_only || reg_idx < 5'h08)))
    else $error("register visibility wrong");
  a_reg_map: assert property (
    reg_mapped == (reg_idx >= 5'h08)) else $error("register map wrong");
endmodule : issw_properties
bind issw_mode_switch issw_properties u_props (.*);

/* File: test_instruction_set_mode_switch.sv */
`timescale 1ns/1ps
// Drives the mode switch and scores committed results
module test_instruction_set_mode_switch;
  import issw_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("FAIL %0t %h %h", $time, (a), (b)); end end
  logic clock = 0, rst_n = 0, operand_16 = 0, interrupt_req = 0;
  logic ret_to_legacy = 0, transition_disable_bit = 0, fp_pending = 0;
  logic cs_priv_bad = 0, sys_access = 0, reg_is_native_only = 0;
  issw_op_t op = ISSW_OP_NONE; // Request kind
  issw_lmode_t lmode_setup = ISSW_LM_PROT, lmode; // Legacy sub-mode
  logic [31:0] operand = 0, code_segment_base = 0, seg_base = 0;
  logic [31:0] code_segment_limit = 32'hFFFFFFF0, legacy_instruction_pointer;
  logic [63:0] ret_pointer = 0, int_vector = 64'h100, va_in = 0, va_out;
  logic [63:0] native_instruction_pointer; // Committed pointer
  logic [1:0] cpl_in = 0, cpl_out;
  logic [4:0] reg_idx = 0;
  logic [2:0] fault_code;
  logic instruction_set_select_bit, redirect, fault_valid, xlate_en;
  logic seg_check_en, force_le, narrow_ops, reg_hidden, reg_mapped;
  int n_errors = 0, cmp_count = 0, seed = 12;
  logic exp_sel = 0; // Model select bit
  logic [63:0] exp_ip = 0; // Model pointer
  logic [67:0] q[$], e; // Expected notes
  wire [67:0] got = {instruction_set_select_bit,
    fault_valid ? fault_code : 3'h0, native_instruction_pointer};
  issw_mode_switch DUT (.*);
  // Clock at 40 MHz
  always #12.5 clock = ~clock;
  // Side inputs wander every cycle
  always @(negedge clock) begin
    {cpl_in, reg_idx, reg_is_native_only} = 8'($random(seed));
    va_in = {$random(seed), $random(seed)};
    seg_base = $random(seed);
  end
  // Oldest note against each result
  always @(negedge clock) begin
    if (redirect === 1'b1 || fault_valid === 1'b1) begin
      `CHK(q.size() > 0, 1'b1)
      if (q.size() > 0) begin
        e = q.pop_front();
        `CHK(got, e)
      end
    end
  end
  // Note one expected result
  task push(input logic [2:0] c);
    q.push_back({exp_sel, c, exp_ip});
  endtask : push
  // Issue one request, op held until next call or idle
  task go(input issw_op_t o, input logic [31:0] d);
    logic [31:0] v;
    op = o;
    operand = d;
    v = (operand_16 ? {16'h0, d[15:0]} : d) + code_segment_base;
    if (o == ISSW_OP_RETURN) begin
      exp_sel = ret_to_legacy;
      exp_ip = ret_pointer;
      push(3'h0);
    end else if ((o == ISSW_OP_BR_LEGACY) == exp_sel) begin
      // Wrong direction, ignored
    end else if (transition_disable_bit) begin
      push(3'h1);
    end else if (o != ISSW_OP_BR_LEGACY && fp_pending) begin
      push(3'h2);
    end else if (o != ISSW_OP_BR_LEGACY) begin
      exp_sel = 0;
      exp_ip = {32'h0, v[31:4], 4'h0};
      push(3'h0);
    end else begin
      exp_sel = 1;
      exp_ip = {32'h0, d};
      push((d - code_segment_base > code_segment_limit || cs_priv_bad) ?
           3'h3 : 3'h0);
    end
    @(negedge clock);
  endtask : go
  // Drop the request for a cycle
  task idle;
    op = ISSW_OP_NONE;
    @(negedge clock);
  endtask : idle
  // Verdict and end of run
  task test_done;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1;
    `CHK(instruction_set_select_bit, 1'b0)
    go(ISSW_OP_JMP_ABS, 32'h12345678);
    for (int i = 0; i < 8; i++) begin
      code_segment_base = $random(seed);
      cs_priv_bad = (i == 5);
      lmode_setup = i[1] ? ISSW_LM_V86 : ISSW_LM_PROT;
      go(ISSW_OP_BR_LEGACY, $random(seed));
      cs_priv_bad = 0;
      operand_16 = i[0];
      go(i[1] ? ISSW_OP_JMP_REG : ISSW_OP_JMP_ABS, $random(seed));
      operand_16 = 0;
    end
    code_segment_base = 0;
    transition_disable_bit = 1;
    go(ISSW_OP_BR_LEGACY, 32'h100);
    transition_disable_bit = 0;
    go(ISSW_OP_BR_LEGACY, 32'hFFFFFFF8);
    transition_disable_bit = 1;
    go(ISSW_OP_JMP_ABS, 32'h40);
    transition_disable_bit = 0;
    fp_pending = 1;
    go(ISSW_OP_JMP_REG, 32'h40);
    fp_pending = 0;
    transition_disable_bit = 1;
    idle;
    sys_access = 1;
    push(3'h4);
    @(negedge clock);
    sys_access = 0;
    interrupt_req = 1;
    exp_sel = 0;
    exp_ip = int_vector;
    push(3'h0);
    @(negedge clock);
    interrupt_req = 0;
    ret_to_legacy = 1;
    ret_pointer = {$random(seed), $random(seed)};
    go(ISSW_OP_RETURN, 32'h0);
    ret_to_legacy = 0;
    go(ISSW_OP_RETURN, 32'h0);
    transition_disable_bit = 0;
    go(ISSW_OP_BR_LEGACY, 32'h300);
    idle;
    rst_n = 0;
    repeat (2) @(negedge clock);
    `CHK(instruction_set_select_bit, 1'b0)
    `CHK(native_instruction_pointer, 64'h0)
    rst_n = 1;
    exp_sel = 0;
    exp_ip = 0;
    go(ISSW_OP_BR_LEGACY, 32'h80);
    idle;
    `CHK(q.size(), 0)
    test_done;
  end
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    test_done;
  end
endmodule : test_instruction_set_mode_switch
